// File: design/element_descriptor_builder.sv
`timescale 1ns/10ps
`default_nettype none
module element_descriptor_builder
  import edb_pkg::*;
#(
  parameter int FIXED_SLOTS   = 4,
  parameter int SLOTS_PER_MAG = 10,
  parameter int NUM_MAGS      = 4
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_start,
  input  wire elem_type_e           i_elem_type,
  input  wire logic [15:0]          i_elem_addr,
  input  wire logic                 i_volume_tag_request_flag,
  input  wire logic                 i_full,
  input  wire logic                 i_except,
  input  wire logic [7:0]           i_asc,
  input  wire logic [7:0]           i_ascq,
  input  wire logic                 i_src_known,
  input  wire elem_type_e           i_src_type,
  input  wire logic [15:0]          i_src_addr,
  input  wire logic [287:0]         i_vol_tag,
  input  wire logic                 i_seq_reserved,
  input  wire logic                 i_mag_installed,
  input  wire logic                 i_io_retracted,
  input  wire logic                 i_cfg_front_access,
  input  wire logic                 i_cfg_export,
  input  wire logic                 i_cfg_import,
  input  wire logic                 i_operator_placed,
  input  wire logic                 i_cfg_src_drive,
  input  wire logic                 i_cfg_src_io,
  input  wire logic [NUM_MAGS-1:0]  i_mags_present,
  input  wire logic                 i_ready,
  output logic                      o_busy,
  output logic                      o_valid,
  output logic [7:0]                o_data,
  output logic                      o_last,
  output logic [5:0]                o_desc_len,
  output logic [15:0]               o_storage_count,
  output logic [15:0]               o_handler_count
);

  typedef enum logic {ST_IDLE, ST_SEND} state_e;

  state_e         state;
  logic [5:0]     idx;
  logic [5:0]     out_idx;
  logic [5:0]     len;
  logic           load;
  logic           accept;
  logic [7:0]     next_byte;

  elem_type_e     type_q;
  logic [15:0]    addr_q;
  logic           vt_q;
  logic           full_q;
  logic           except_q;
  logic [7:0]     asc_q;
  logic [7:0]     ascq_q;
  logic           src_known_q;
  elem_type_e     src_type_q;
  logic [15:0]    src_addr_q;
  logic [287:0]   tag_q;
  logic           seq_q;
  logic           mag_q;
  logic           retr_q;
  logic           front_q;
  logic           exp_q;
  logic           imp_q;
  logic           oper_q;
  logic           cfg_drv_q;
  logic           cfg_io_q;

  elem_flags_if fif ();

  // ==========================================================================
  // Flag encoder on the snapshot
  assign fif.elem_type        = type_q;
  assign fif.full             = full_q;
  assign fif.except           = except_q;
  assign fif.seq_reserved     = seq_q;
  assign fif.mag_installed    = mag_q;
  assign fif.io_retracted     = retr_q;
  assign fif.cfg_front_access = front_q;
  assign fif.cfg_export       = exp_q;
  assign fif.cfg_import       = imp_q;
  assign fif.operator_placed  = oper_q;
  assign fif.src_known        = src_known_q;
  assign fif.src_type         = src_type_q;
  assign fif.cfg_src_drive    = cfg_drv_q;
  assign fif.cfg_src_io       = cfg_io_q;

  elem_flag_encoder u_enc (
    .f (fif.encoder)
  );

  // ==========================================================================
  // Handshake
  assign o_busy = (state != ST_IDLE) || o_valid;
  assign accept = i_start && !o_busy;
  assign load   = (state == ST_SEND) && (!o_valid || i_ready);

  // ==========================================================================
  // Snapshot: state is frozen so one descriptor is self-consistent
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      type_q      <= ELEM_HANDLER;
      addr_q      <= 16'h0000;
      vt_q        <= 1'b0;
      full_q      <= 1'b0;
      except_q    <= 1'b0;
      asc_q       <= 8'h00;
      ascq_q      <= 8'h00;
      src_known_q <= 1'b0;
      src_type_q  <= ELEM_STORAGE;
      src_addr_q  <= 16'h0000;
      seq_q       <= 1'b0;
      mag_q       <= 1'b0;
      retr_q      <= 1'b0;
      front_q     <= 1'b0;
      exp_q       <= 1'b0;
      imp_q       <= 1'b0;
      oper_q      <= 1'b0;
      cfg_drv_q   <= 1'b0;
      cfg_io_q    <= 1'b0;
    end else if (accept) begin
      type_q      <= i_elem_type;
      addr_q      <= i_elem_addr;
      vt_q        <= i_volume_tag_request_flag;
      full_q      <= i_full;
      except_q    <= i_except;
      asc_q       <= i_asc;
      ascq_q      <= i_ascq;
      src_known_q <= i_src_known;
      src_type_q  <= i_src_type;
      src_addr_q  <= i_src_addr;
      seq_q       <= i_seq_reserved;
      mag_q       <= i_mag_installed;
      retr_q      <= i_io_retracted;
      front_q     <= i_cfg_front_access;
      exp_q       <= i_cfg_export;
      imp_q       <= i_cfg_import;
      oper_q      <= i_operator_placed;
      cfg_drv_q   <= i_cfg_src_drive;
      cfg_io_q    <= i_cfg_src_io;
    end
  end

  // ==========================================================================
  // Volume tag shifts out first byte from the top
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tag_q <= '0;
    end else if (accept) begin
      tag_q <= i_vol_tag;
    end else if (load && vt_q && idx >= BYTE_TAG_FIRST && idx <= BYTE_TAG_LAST) begin
      tag_q <= {tag_q[279:0], 8'h00};
    end
  end

  // ==========================================================================
  // Byte selection
  always_comb begin
    next_byte = 8'h00;
    if (idx == BYTE_ADDR_HI) begin
      next_byte = addr_q[15:8];
    end else if (idx == BYTE_ADDR_LO) begin
      next_byte = addr_q[7:0];
    end else if (idx == BYTE_FLAGS) begin
      next_byte = fif.flags;
    end else if (idx == BYTE_ASC) begin
      next_byte = except_q ? asc_q : 8'h00;
    end else if (idx == BYTE_ASCQ) begin
      next_byte = except_q ? ascq_q : 8'h00;
    end else if (idx == BYTE_SRC_FLAGS) begin
      next_byte[BIT_SVALID] = fif.svalid;
      next_byte[BIT_INVERT] = 1'b0;
    end else if (idx == BYTE_SRC_HI) begin
      next_byte = fif.svalid ? src_addr_q[15:8] : 8'h00;
    end else if (idx == BYTE_SRC_LO) begin
      next_byte = fif.svalid ? src_addr_q[7:0] : 8'h00;
    end else if (vt_q && idx >= BYTE_TAG_FIRST && idx <= BYTE_TAG_LAST) begin
      next_byte = tag_q[287:280];
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      idx   <= 6'h00;
      len   <= DESC_LEN_NOTAG;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            state <= ST_SEND;
            idx   <= 6'h00;
            len   <= i_volume_tag_request_flag ? DESC_LEN_TAG : DESC_LEN_NOTAG;
          end
        end
        ST_SEND: begin
          if (load) begin
            idx <= idx + 6'h01;
            if (idx == len - 6'h01) begin
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Output byte register; holds while the reader stalls
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data  <= 8'h00;
      o_last  <= 1'b0;
      out_idx <= 6'h00;
    end else if (load) begin
      o_valid <= 1'b1;
      o_data  <= next_byte;
      o_last  <= (idx == len - 6'h01);
      out_idx <= idx;
    end else if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      o_last  <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_desc_len <= DESC_LEN_NOTAG;
    end else if (accept) begin
      o_desc_len <= i_volume_tag_request_flag ? DESC_LEN_TAG : DESC_LEN_NOTAG;
    end
  end

  // ==========================================================================
  // Element counts
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_storage_count <= 16'h0000;
    end else begin
      o_storage_count <= 16'(FIXED_SLOTS + SLOTS_PER_MAG * $countones(i_mags_present));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_handler_count <= 16'h0000;
    end else begin
      o_handler_count <= HANDLER_COUNT;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_SVALID_GATE: assert property (
    o_valid && out_idx == BYTE_SRC_FLAGS && !(src_known_q && full_q) |-> o_data == 8'h00)
    else $error("source valid set without known source");
  AST_INVERT_ZERO: assert property (
    o_valid && out_idx == BYTE_SRC_FLAGS |-> !o_data[BIT_INVERT])
    else $error("invert bit not zero");
  AST_SRC_ADDR: assert property (
    o_valid && out_idx == BYTE_SRC_LO && fif.svalid |-> o_data == src_addr_q[7:0])
    else $error("source address low byte wrong");
  AST_SRC_ADMIT: assert property (
    fif.svalid && src_type_q == ELEM_DRIVE |-> cfg_drv_q)
    else $error("drive source used without permission");
  AST_DESC_LEN: assert property (
    o_valid && o_last |-> out_idx == (vt_q ? 6'h33 : 6'h0f))
    else $error("descriptor length wrong");
  AST_STREAM_START: assert property (
    accept |=> !o_valid ##1 o_valid && out_idx == BYTE_ADDR_HI)
    else $error("descriptor does not start on time");
  AST_PAD_ZERO: assert property (
    o_valid && out_idx >= BYTE_PAD_FIRST |-> o_data == 8'h00)
    else $error("pad bytes not zero");
  AST_STORAGE_FLAGS: assert property (
    o_valid && out_idx == BYTE_FLAGS && type_q == ELEM_STORAGE
      |-> o_data[7:4] == 4'h0 && !o_data[BIT_OPER]
        && o_data[BIT_ACCESS] == (!seq_q && mag_q))
    else $error("storage flag byte wrong");
  AST_IO_FRONT: assert property (
    o_valid && out_idx == BYTE_FLAGS && type_q == ELEM_IO && front_q
      |-> !o_data[BIT_ACCESS])
    else $error("port access not forced low");
  AST_ASC_QUIET: assert property (
    o_valid && out_idx == BYTE_ASC && !except_q |-> o_data == 8'h00)
    else $error("sense code without exception");
  AST_ADDR_MSB: assert property (
    o_valid && out_idx == BYTE_ADDR_HI |-> o_data == addr_q[15:8])
    else $error("address not most significant first");
  AST_HOLD: assert property (
    o_valid && !i_ready |=> o_valid && $stable(o_data))
    else $error("byte dropped under stall");
  AST_NO_TAG_ZERO: assert property (
    o_valid && !vt_q && out_idx >= BYTE_TAG_FIRST |-> o_data == 8'h00)
    else $error("tag bytes sent without request");
  AST_IO_PERMIT: assert property (
    o_valid && out_idx == BYTE_FLAGS && type_q == ELEM_IO
      |-> o_data[BIT_EXPORT] == exp_q && o_data[BIT_IMPORT] == imp_q)
    else $error("port permit flags wrong");
  AST_OPER_FLAG: assert property (
    o_valid && out_idx == BYTE_FLAGS && type_q == ELEM_IO |-> o_data[BIT_OPER] == oper_q)
    else $error("operator placed flag wrong");

  COV_TAG_DESC:   cover property (accept && i_volume_tag_request_flag ##[1:150] o_last);
  COV_EXCEPT:     cover property (o_valid && out_idx == BYTE_ASC && except_q);
  COV_IO_DESC:    cover property (o_valid && out_idx == BYTE_FLAGS && type_q == ELEM_IO);
  COV_SVALID:     cover property (o_valid && out_idx == BYTE_SRC_FLAGS && o_data[BIT_SVALID]);
  COV_STALL:      cover property (o_valid && !i_ready ##1 o_valid && i_ready);

endmodule
`default_nettype wire

// File: design/edb_pkg.sv
package edb_pkg;

  // ==========================================================================
  // Element kinds
  typedef enum logic [1:0] {
    ELEM_HANDLER,
    ELEM_STORAGE,
    ELEM_IO,
    ELEM_DRIVE
  } elem_type_e;

  // ==========================================================================
  // Descriptor lengths
  localparam logic [5:0] TAG_BYTES      = 6'h24;
  localparam logic [5:0] DESC_LEN_TAG   = 6'h34;
  localparam logic [5:0] DESC_LEN_NOTAG = 6'h10;
  localparam logic [15:0] HANDLER_COUNT = 16'h0001;

  // ==========================================================================
  // Byte offsets inside a descriptor
  localparam logic [5:0] BYTE_ADDR_HI   = 6'h00;
  localparam logic [5:0] BYTE_ADDR_LO   = 6'h01;
  localparam logic [5:0] BYTE_FLAGS     = 6'h02;
  localparam logic [5:0] BYTE_ASC       = 6'h04;
  localparam logic [5:0] BYTE_ASCQ      = 6'h05;
  localparam logic [5:0] BYTE_SRC_FLAGS = 6'h09;
  localparam logic [5:0] BYTE_SRC_HI    = 6'h0a;
  localparam logic [5:0] BYTE_SRC_LO    = 6'h0b;
  localparam logic [5:0] BYTE_TAG_FIRST = 6'h0c;
  localparam logic [5:0] BYTE_TAG_LAST  = 6'h2f;
  localparam logic [5:0] BYTE_PAD_FIRST = 6'h30;

  // ==========================================================================
  // Bit positions in the flag byte and the source byte
  localparam int BIT_FULL   = 0;
  localparam int BIT_OPER   = 1;
  localparam int BIT_EXCEPT = 2;
  localparam int BIT_ACCESS = 3;
  localparam int BIT_EXPORT = 4;
  localparam int BIT_IMPORT = 5;
  localparam int BIT_INVERT = 6;
  localparam int BIT_SVALID = 7;

endpackage

// File: design/elem_flags_if.sv
`timescale 1ns/10ps
`default_nettype none
interface elem_flags_if;
  import edb_pkg::*;
  elem_type_e elem_type;
  logic       full;
  logic       except;
  logic       seq_reserved;
  logic       mag_installed;
  logic       io_retracted;
  logic       cfg_front_access;
  logic       cfg_export;
  logic       cfg_import;
  logic       operator_placed;
  logic       src_known;
  elem_type_e src_type;
  logic       cfg_src_drive;
  logic       cfg_src_io;
  logic [7:0] flags;
  logic       svalid;

  modport builder (
    output elem_type, full, except, seq_reserved, mag_installed, io_retracted,
           cfg_front_access, cfg_export, cfg_import, operator_placed,
           src_known, src_type, cfg_src_drive, cfg_src_io,
    input  flags, svalid
  );
  modport encoder (
    input  elem_type, full, except, seq_reserved, mag_installed, io_retracted,
           cfg_front_access, cfg_export, cfg_import, operator_placed,
           src_known, src_type, cfg_src_drive, cfg_src_io,
    output flags, svalid
  );
endinterface
`default_nettype wire

// File: design/elem_flag_encoder.sv
`timescale 1ns/10ps
`default_nettype none
module elem_flag_encoder
  import edb_pkg::*;
(
  elem_flags_if.encoder f
);

  // ==========================================================================
  // Flag byte per element kind
  always_comb begin
    f.flags = 8'h00;
    unique case (f.elem_type)
      ELEM_HANDLER: begin
        f.flags[BIT_EXCEPT] = f.except;
        f.flags[BIT_FULL]   = f.full;
      end
      ELEM_STORAGE: begin
        f.flags[BIT_ACCESS] = !f.seq_reserved && f.mag_installed;
        f.flags[BIT_EXCEPT] = f.except;
        f.flags[BIT_FULL]   = f.full;
      end
      ELEM_IO: begin
        f.flags[BIT_IMPORT] = f.cfg_import;
        f.flags[BIT_EXPORT] = f.cfg_export;
        // Front access hides the retract state entirely
        f.flags[BIT_ACCESS] = f.io_retracted && !f.cfg_front_access;
        f.flags[BIT_EXCEPT] = f.except;
        f.flags[BIT_OPER]   = f.operator_placed;
        f.flags[BIT_FULL]   = f.full;
      end
      ELEM_DRIVE: begin
        f.flags[BIT_EXCEPT] = f.except;
        f.flags[BIT_FULL]   = f.full;
      end
    endcase
  end

  // ==========================================================================
  // Source tracking: only admitted source kinds count
  always_comb begin
    logic admitted;
    admitted = 1'b0;
    unique case (f.src_type)
      ELEM_STORAGE: admitted = 1'b1;
      ELEM_DRIVE:   admitted = f.cfg_src_drive;
      ELEM_IO:      admitted = f.cfg_src_io;
      ELEM_HANDLER: admitted = 1'b0;
    endcase
    // Empty element has no meaningful source
    f.svalid = f.src_known && f.full && admitted;
  end

endmodule
`default_nettype wire

// File: verif/desc_reader.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Reader that takes descriptor bytes at the far side
module desc_reader (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clear,
  input  wire logic       i_stall,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_last,
  output logic            o_ready,
  output logic            o_done,
  output logic [6:0]      o_count,
  output logic [7:0]      o_bytes [64]
);
  // Alternate stalls prove each byte stands until it is taken
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= i_stall ? ~o_ready : 1'b1;
    end
  end

  // Bytes past the last one still bump the count, so extras are seen
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      o_count <= 7'h00;
      o_done  <= 1'b0;
    end else if (i_valid && o_ready) begin
      o_bytes[o_count[5:0]] <= i_data;
      o_count               <= o_count + 7'h01;
      if (i_last) begin
        o_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/element_descriptor_builder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module element_descriptor_builder_tb
  import edb_pkg::*;
;
  localparam int FS = 2;
  localparam int SPM = 5;
  localparam int NM = 3;
  logic clk = 0, rst = 1, start = 0, vtr = 0, full = 0, exc = 0, src_known = 0;
  logic seq_res = 0, mag_inst = 0, retr = 0, front = 0, cfg_exp = 0, cfg_imp = 0;
  logic oper = 0, cfg_sdrv = 0, cfg_sio = 0, clear = 0, stall = 0;
  elem_type_e etype = ELEM_HANDLER, src_type = ELEM_HANDLER;
  logic [15:0] eaddr = 16'h0000, saddr = 16'h0000;
  logic [7:0] asc = 8'h00, ascq = 8'h00;
  logic [287:0] vtag = '0;
  logic [NM-1:0] mags = 3'h5;
  logic busy, valid, last, ready, done;
  logic [7:0] data;
  logic [5:0] dlen;
  logic [15:0] scount, hcount;
  logic [6:0] cnt;
  logic [7:0] bytes [64];
  int n_errors = 0;
  int tests_run = 0;

  always #10 clk = ~clk;

  element_descriptor_builder #(.FIXED_SLOTS(FS), .SLOTS_PER_MAG(SPM), .NUM_MAGS(NM))
  i_element_descriptor_builder (.i_clk(clk), .i_rst(rst), .i_start(start),
    .i_elem_type(etype), .i_elem_addr(eaddr), .i_volume_tag_request_flag(vtr),
    .i_full(full), .i_except(exc), .i_asc(asc), .i_ascq(ascq),
    .i_src_known(src_known), .i_src_type(src_type), .i_src_addr(saddr),
    .i_vol_tag(vtag), .i_seq_reserved(seq_res), .i_mag_installed(mag_inst),
    .i_io_retracted(retr), .i_cfg_front_access(front), .i_cfg_export(cfg_exp),
    .i_cfg_import(cfg_imp), .i_operator_placed(oper), .i_cfg_src_drive(cfg_sdrv),
    .i_cfg_src_io(cfg_sio), .i_mags_present(mags), .i_ready(ready), .o_busy(busy),
    .o_valid(valid), .o_data(data), .o_last(last), .o_desc_len(dlen),
    .o_storage_count(scount), .o_handler_count(hcount));

  desc_reader i_desc_reader (.i_clk(clk), .i_rst(rst), .i_clear(clear), .i_stall(stall),
    .i_valid(valid), .i_data(data), .i_last(last), .o_ready(ready), .o_done(done),
    .o_count(cnt), .o_bytes(bytes));

  // ============================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic src_ok();
    return src_known && full && (src_type == ELEM_STORAGE ||
      (src_type == ELEM_DRIVE && cfg_sdrv) || (src_type == ELEM_IO && cfg_sio));
  endfunction

  function automatic logic [7:0] exp_byte(input int k);
    logic [7:0] fl;
    fl = {5'h00, exc, 1'b0, full};
    if (etype == ELEM_STORAGE) fl[3] = !seq_res && mag_inst;
    if (etype == ELEM_IO) fl = {2'b00, cfg_imp, cfg_exp, retr && !front, exc, oper, full};
    case (k)
      0: return eaddr[15:8];
      1: return eaddr[7:0];
      2: return fl;
      4: return exc ? asc : 8'h00;
      5: return exc ? ascq : 8'h00;
      9: return {src_ok(), 7'h00};
      10: return src_ok() ? saddr[15:8] : 8'h00;
      11: return src_ok() ? saddr[7:0] : 8'h00;
      default: return (k >= 12 && k < 48 && vtr) ? vtag[287 - 8 * (k - 12) -: 8] : 8'h00;
    endcase
  endfunction

  // Second start and address change while busy must both be ignored
  task automatic run_desc();
    int n;
    int len;
    @(posedge clk);
    start <= 1'b1;
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    eaddr <= ~eaddr;
    @(posedge clk);
    start <= 1'b0;
    eaddr <= ~eaddr;
    check(16'(busy), 16'h0001);
    n = 0;
    while (done !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 300) begin
        n_errors++;
        complete_run();
      end
    end
    #1;
    check(16'(busy), 16'h0000);
    len = vtr ? 52 : 16;
    check(16'(cnt), 16'(len));
    check(16'(dlen), 16'(len));
    for (int k = 0; k < len; k++) check(bytes[k], exp_byte(k));
  endtask

  // ============================================================
  // Scenarios
  task automatic t_counts();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      mags <= 3'(i);
      repeat (3) @(posedge clk);
      #1;
      check(scount, 16'(FS + SPM * $countones(3'(i))));
      check(hcount, 16'h0001);
    end
  endtask

  task automatic t_storage();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      etype <= ELEM_STORAGE;
      src_type <= ELEM_STORAGE;
      {vtr, full, src_known} <= {1'b0, 1'b1, 1'b1};
      {eaddr, saddr, asc, ascq} <= {16'ha05c, 16'h1234, 8'h83, 8'h02};
      {seq_res, mag_inst, exc} <= {i[0], i[1], i[0]};
      run_desc();
      check(bytes[2][3], !i[0] && i[1]);
      check(bytes[2] & 8'hf2, 8'h00);
    end
  endtask

  task automatic t_handler_tag();
    @(posedge clk);
    etype <= ELEM_HANDLER;
    {vtr, exc, stall} <= {1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 36; i++) vtag[287 - 8 * i -: 8] <= 8'h40 + 8'(i);
    run_desc();
    check(bytes[12], 8'h40);
    @(posedge clk);
    stall <= 1'b0;
  endtask

  task automatic t_io();
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      etype <= ELEM_IO;
      vtr <= 1'b0;
      {retr, front, cfg_exp, cfg_imp, oper, full} <= {i[0], i[1], i[2], i[3], i[4], i[1]};
      run_desc();
      check(bytes[2][3], i[0] && !i[1]);
      check(bytes[2][4], i[2]);
      check(bytes[2][5], i[3]);
      check(bytes[2][1], i[4]);
      check(bytes[2][0], i[1]);
    end
  endtask

  task automatic t_source();
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      {seq_res, mag_inst, full, saddr} <= {1'b0, 1'b1, 1'b1, 16'hc3e1};
      etype <= i[0] ? ELEM_DRIVE : ELEM_STORAGE;
      src_type <= elem_type_e'(i[1:0]);
      {cfg_sdrv, cfg_sio, src_known} <= {i[2], i[3], !i[4]};
      run_desc();
      check(bytes[9][6], 1'b0);
      check(bytes[9][7], !i[4] && (i[1:0] == 2'h1 || (i[1:0] == 2'h3 && i[2])
        || (i[1:0] == 2'h2 && i[3])));
      check({bytes[10], bytes[11]}, bytes[9][7] ? 16'hc3e1 : 16'h0000);
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(16'(dlen), 16'h0010);
    check(16'(valid), 16'h0000);
    t_counts();
    t_storage();
    t_handler_tag();
    t_io();
    t_source();
    complete_run();
  end
endmodule
`default_nettype wire
